// [design/tcb_timer.sv]
// Purpose: Counter, compare and 16-bit access path of the 8/16-bit timer.
// Assumes: Bus strobes and timer tick are synchronous to clk.
// Notes: Flags leave as one-cycle event pulses; flag storage lives outside.
`timescale 1ns/1ps
module tcb_timer
   import tcb_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire tcb_bus_t bus,
   input wire logic timer_tick,
   input wire logic capture_strobe,
   output tcb_evt_t evt,
   output logic capture_event,
   output logic [7:0] rdata,
   output logic [7:0] timer_control_a
);

   // ***********************************************
   // State
   // ***********************************************
   logic [7:0] ctrl_r;
   logic [7:0] cnt_lo_r;
   logic [7:0] cnt_hi_r;
   logic [7:0] cmp_a_r;
   logic [7:0] cmp_b_r;
   logic [7:0] temp_r;
   logic block_r;
   logic [7:0] rdata_r;
   tcb_evt_t evt_r;
   logic capt_r;

   // ***********************************************
   // Mode decode
   // ***********************************************
   wire logic wide = ctrl_r[TCB_BIT_WIDTH];
   wire logic capt_en = ctrl_r[TCB_BIT_CAPT];
   wire logic clear_on_match = ctrl_r[TCB_BIT_CTC];
   // Mode chosen from width, capture enable and clear-on-match
   wire tcb_mode_t mode = capt_en ? (wide ? TCB_MODE_CAPT16 : TCB_MODE_CAPT8)
                        : wide ? TCB_MODE_NORM16
                        : clear_on_match ? TCB_MODE_CTC8 : TCB_MODE_NORM8;
   wire logic is_ctc = (mode == TCB_MODE_CTC8);
   wire logic is_16 = (mode == TCB_MODE_NORM16) || (mode == TCB_MODE_CAPT16);
   wire logic cap16 = (mode == TCB_MODE_CAPT16);

   // ***********************************************
   // Bus decode
   // ***********************************************
   wire logic wr_ctrl = bus.wr && (bus.addr == TCB_ADDR_CTRL_A);
   wire logic wr_clo = bus.wr && (bus.addr == TCB_ADDR_CNT_LO);
   wire logic wr_chi = bus.wr && (bus.addr == TCB_ADDR_CNT_HI);
   wire logic wr_ca = bus.wr && (bus.addr == TCB_ADDR_CMP_A);
   wire logic wr_cb = bus.wr && (bus.addr == TCB_ADDR_CMP_B);
   wire logic rd_clo = bus.rd && (bus.addr == TCB_ADDR_CNT_LO);
   wire logic rd_ca = bus.rd && (bus.addr == TCB_ADDR_CMP_A);
   // High byte is latched only in 16-bit mode; 8-bit writes hit the byte directly
   wire logic hi_via_temp = is_16;
   // Compare B acts as high byte of the pair only in 16-bit mode
   wire logic cb_via_temp = is_16;

   // ***********************************************
   // Counter arithmetic
   // ***********************************************
   wire logic [15:0] cnt16 = {cnt_hi_r, cnt_lo_r};
   wire logic [15:0] cmp16 = {cmp_b_r, cmp_a_r}; // A low, B high
   wire logic [15:0] inc16 = cnt16 + 16'h0001; // Wraps 0xFFFF to 0x0000
   wire logic [7:0] inc8 = cnt_lo_r + 8'h01;
   // Equality test; a compare written below the count waits for the wrap
   wire logic match_a8 = (cnt_lo_r == cmp_a_r);
   wire logic match_b8 = (cnt_lo_r == cmp_b_r);
   wire logic match16 = (cnt16 == cmp16);
   // Compare units are unavailable while compare registers hold a capture
   wire logic cmp_a_live = !capt_en;
   wire logic cmp_b_live = !cap16;
   wire logic hit_a = cmp_a_live && (is_16 ? match16 : match_a8);
   wire logic hit_b = cmp_b_live && !is_16 && match_b8;
   // Clear on match, compare A is top
   wire logic ctc_clear = is_ctc && match_a8;
   wire logic ovf8 = !is_16 && !ctc_clear && (cnt_lo_r == TCB_MAX8);
   wire logic ovf16 = is_16 && (cnt16 == TCB_MAX16);
   wire logic [15:0] cnt_next = ctc_clear ? 16'h0000
                              : is_16 ? inc16 : {cnt_hi_r, inc8};
   // Tick that really advances; a CPU write to the counter wins this cycle
   wire logic cpu_cnt_wr = wr_clo || (wr_chi && !hi_via_temp);
   wire logic advance = timer_tick && !cpu_cnt_wr;

   // ***********************************************
   // Read data mux
   // ***********************************************
   logic [7:0] rd_mux;
   always_comb
   begin
      unique case (bus.addr)
         TCB_ADDR_CTRL_A: rd_mux = ctrl_r & TCB_CTRL_A_WMASK; // reserved read zero
         TCB_ADDR_CNT_LO: rd_mux = cnt_lo_r;
         // Counter high byte comes from the latch in 16-bit mode, direct in 8-bit modes
         TCB_ADDR_CNT_HI: rd_mux = is_16 ? temp_r : cnt_hi_r;
         TCB_ADDR_CMP_A: rd_mux = cmp_a_r;
         // Capture high byte via latch compare bytes direct
         TCB_ADDR_CMP_B: rd_mux = cap16 ? temp_r : cmp_b_r;
         default: rd_mux = TCB_BYTE_RST;
      endcase
   end

   // ***********************************************
   // Shared high-byte latch
   // ***********************************************
   // One latch for every pair; holds until rewritten so it can be reused
   logic [7:0] temp_nxt;
   always_comb
   begin
      temp_nxt = temp_r;
      if ((wr_chi && hi_via_temp) || (wr_cb && cb_via_temp))
         temp_nxt = bus.wdata;
      else if (rd_clo && is_16)
         temp_nxt = cnt_hi_r;
      else if (rd_ca && cap16)
         temp_nxt = cmp_b_r;
   end

   // ***********************************************
   // Control register A
   // ***********************************************
   always_ff @(posedge clk)
   begin
      if (!resetn)
         ctrl_r <= TCB_CTRL_A_RST;
      else if (wr_ctrl)
         ctrl_r <= bus.wdata & TCB_CTRL_A_WMASK;
   end

   // ***********************************************
   // Counter
   // ***********************************************
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         cnt_lo_r <= TCB_BYTE_RST;
         cnt_hi_r <= TCB_BYTE_RST;
      end
      else if (wr_clo)
      begin
         cnt_lo_r <= bus.wdata;
         if (hi_via_temp)
            cnt_hi_r <= temp_r; // Both bytes in one cycle
      end
      else if (wr_chi && !hi_via_temp)
         cnt_hi_r <= bus.wdata;
      else if (advance)
      begin
         cnt_lo_r <= cnt_next[7:0];
         cnt_hi_r <= cnt_next[15:8];
      end
   end

   // ***********************************************
   // Compare / capture registers
   // ***********************************************
   // Writes take effect at once, no double buffering
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         cmp_a_r <= TCB_BYTE_RST;
         cmp_b_r <= TCB_BYTE_RST;
      end
      else if (capture_strobe && capt_en)
      begin
         cmp_a_r <= cnt_lo_r;
         if (cap16)
            cmp_b_r <= cnt_hi_r;
      end
      else
      begin
         if (wr_ca)
            cmp_a_r <= bus.wdata;
         if (wr_ca && cb_via_temp)
            cmp_b_r <= temp_r;
         else if (wr_cb && !cb_via_temp)
            cmp_b_r <= bus.wdata;
      end
   end

   // ***********************************************
   // Latch, match blocking and read data
   // ***********************************************
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         temp_r <= TCB_BYTE_RST;
         block_r <= 1'b0;
         rdata_r <= TCB_BYTE_RST;
      end
      else
      begin
         temp_r <= temp_nxt;
         // Armed by any counter write, even stopped; spent on next tick
         if (cpu_cnt_wr || wr_chi)
            block_r <= 1'b1;
         else if (timer_tick)
            block_r <= 1'b0;
         rdata_r <= bus.rd ? rd_mux : rdata_r;
      end
   end

   // ***********************************************
   // Event pulses
   // ***********************************************
   // Flags pulse the cycle after the tick that acts on the match or rollover
   wire logic blocked = block_r || cpu_cnt_wr;
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         evt_r <= '0;
         capt_r <= 1'b0;
      end
      else
      begin
         evt_r.compare_flag_a <= advance && hit_a && !blocked;
         evt_r.compare_flag_b <= advance && hit_b && !blocked;
         // Overflow only ever set, on rollover to zero
         evt_r.overflow_flag <= advance && (ovf8 || ovf16);
         capt_r <= capture_strobe && capt_en;
      end
   end

   assign evt = evt_r;
   assign capture_event = capt_r;
   assign rdata = rdata_r;
   assign timer_control_a = ctrl_r;

endmodule : tcb_timer

// [design/tcb_pkg.sv]
// Purpose: Constants and carrier types for the 8/16-bit timer core.
// Assumes: 8-bit CPU register port, timer clock arrives as a count enable.
// Notes: Register addresses are the I/O offsets of the register map.
package tcb_pkg;

   // ***********************************************
   // Register addresses
   // ***********************************************
   localparam logic [5:0] TCB_ADDR_CTRL_A = 6'h15;
   localparam logic [5:0] TCB_ADDR_CNT_LO = 6'h32;
   localparam logic [5:0] TCB_ADDR_CNT_HI = 6'h14;
   localparam logic [5:0] TCB_ADDR_CMP_A = 6'h13;
   localparam logic [5:0] TCB_ADDR_CMP_B = 6'h12;

   // ***********************************************
   // Control A field positions and reset
   // ***********************************************
   localparam int TCB_BIT_WIDTH = 7;
   localparam int TCB_BIT_CAPT = 6;
   localparam int TCB_BIT_FILT = 5;
   localparam int TCB_BIT_EDGE = 4;
   localparam int TCB_BIT_SRC = 3;
   localparam int TCB_BIT_CTC = 0;
   localparam logic [7:0] TCB_CTRL_A_WMASK = 8'hF9;
   localparam logic [7:0] TCB_CTRL_A_RST = 8'h00;
   localparam logic [7:0] TCB_BYTE_RST = 8'h00;
   localparam logic [7:0] TCB_MAX8 = 8'hFF;
   localparam logic [15:0] TCB_MAX16 = 16'hFFFF;

   // ***********************************************
   // Carriers
   // ***********************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } tcb_bus_t;

   typedef struct packed {
      logic compare_flag_a;
      logic compare_flag_b;
      logic overflow_flag;
   } tcb_evt_t;

   typedef enum logic [4:0] {
      TCB_MODE_NORM8 = 5'b00001,
      TCB_MODE_CTC8 = 5'b00010,
      TCB_MODE_NORM16 = 5'b00100,
      TCB_MODE_CAPT8 = 5'b01000,
      TCB_MODE_CAPT16 = 5'b10000
   } tcb_mode_t;

endpackage : tcb_pkg

// [testbench/tcb_timer_props.sv]
// Purpose: Port-level properties of the timer core.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every timer instance after the module.
`timescale 1ns/1ps
module tcb_timer_props
   import tcb_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire tcb_bus_t bus,
   input wire logic timer_tick,
   input wire logic capture_strobe,
   input wire tcb_evt_t evt,
   input wire logic capture_event,
   input wire logic [7:0] rdata,
   input wire logic [7:0] timer_control_a
);
   // ************
   // Decodes
   // ************
   wire cnt_wr = bus.wr && (bus.addr == TCB_ADDR_CNT_LO || bus.addr == TCB_ADDR_CNT_HI);
   wire ctl_acc = bus.addr == TCB_ADDR_CTRL_A;
   wire map_hit = bus.addr inside {TCB_ADDR_CTRL_A, TCB_ADDR_CNT_LO, TCB_ADDR_CNT_HI,
      TCB_ADDR_CMP_A, TCB_ADDR_CMP_B};
   logic blk_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Remembers a count write until the next tick consumes it
   always_ff @(posedge clk)
      if (!resetn) blk_r <= 1'b0;
      else if (cnt_wr) blk_r <= 1'b1;
      else if (timer_tick) blk_r <= 1'b0;
   reserved_zero_a:
      assert property (timer_control_a[2:1] == 2'b00) else $error("reserved bits set");
   ctrl_write_a:
      assert property (bus.wr && ctl_acc |=> timer_control_a ==
         ($past(bus.wdata) & TCB_CTRL_A_WMASK)) else $error("control write lost");
   ctrl_read_a:
      assert property (bus.rd && ctl_acc |=> rdata == $past(timer_control_a))
         else $error("control read wrong");
   unmapped_read_a:
      assert property (bus.rd && !map_hit |=> rdata == 8'h00) else $error("hole not zero");
   rdata_hold_a:
      assert property (!bus.rd |=> $stable(rdata)) else $error("read data moved");
   ovf_tick_a:
      assert property (evt.overflow_flag |-> $past(timer_tick)) else $error("stray overflow");
   cmp_tick_a:
      assert property (evt.compare_flag_a || evt.compare_flag_b |-> $past(timer_tick))
         else $error("stray compare");
   match_block_a:
      assert property (timer_tick && blk_r && !cnt_wr |=> !evt.compare_flag_a &&
         !evt.compare_flag_b) else $error("match not blocked");
   capture_pulse_a:
      assert property (capture_event == ($past(capture_strobe) &&
         $past(timer_control_a[TCB_BIT_CAPT]))) else $error("capture pulse wrong");
endmodule : tcb_timer_props
bind tcb_timer tcb_timer_props props_u (.clk(clk), .resetn(resetn), .bus(bus),
   .timer_tick(timer_tick), .capture_strobe(capture_strobe), .evt(evt),
   .capture_event(capture_event), .rdata(rdata), .timer_control_a(timer_control_a));

// [testbench/tcb_cpu.sv]
// Purpose: CPU model driving the timer register port.
// Assumes: Strobes change on the falling edge and stand one cycle.
// Notes: No interrupts, so two-byte accesses are never split.
`timescale 1ns/1ps
module tcb_cpu
   import tcb_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] rdata,
   output tcb_bus_t bus
);
   // ************
   // Accesses
   // ************
   initial bus = '0;
   // One access; read data is settled one edge after the strobe
   task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
      output logic [7:0] q);
   begin
      @(negedge clk);
      bus = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      bus = '0;
      q = rdata;
   end
   endtask : acc
   // Whole pair back to back, nothing in between
   task automatic wr16(input logic [5:0] hi, input logic [5:0] lo, input logic [15:0] v);
      logic [7:0] q;
   begin
      acc(1'b1, hi, v[15:8], q); // High byte first
      acc(1'b1, lo, v[7:0], q);
   end
   endtask : wr16
   task automatic rd16(input logic [5:0] lo, input logic [5:0] hi, output logic [15:0] v);
   begin
      acc(1'b0, lo, 8'h00, v[7:0]); // Low byte first
      acc(1'b0, hi, 8'h00, v[15:8]);
   end
   endtask : rd16
endmodule : tcb_cpu

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the timer core.
// Assumes: Ticks and strobes driven on the falling edge.
// Notes: Event pulses are tallied and checked per test.
`timescale 1ns/1ps
module tb_top;
   import tcb_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic timer_tick = 1'b0;
   logic capture_strobe = 1'b0;
   tcb_bus_t bus;
   tcb_evt_t evt;
   logic capture_event;
   logic [7:0] rdata;
   logic [7:0] ctrl;
   logic [15:0] v;
   int err_count = 0;
   int n_tests = 0;
   int n_a = 0;
   int n_b = 0;
   int n_o = 0;
   initial forever #25 clk = ~clk;
   tcb_cpu cpu_u (.clk(clk), .rdata(rdata), .bus(bus));
   tcb_timer dut_u (.clk(clk), .resetn(resetn), .bus(bus), .timer_tick(timer_tick),
      .capture_strobe(capture_strobe), .evt(evt), .capture_event(capture_event),
      .rdata(rdata), .timer_control_a(ctrl));
   // Event tallies, pulses are one cycle so each counts once
   always @(posedge clk)
   begin
      n_a += int'(evt.compare_flag_a === 1'b1);
      n_b += int'(evt.compare_flag_b === 1'b1);
      n_o += int'(evt.overflow_flag === 1'b1);
   end
   // ************
   // Tasks
   // ************
   task automatic close_out();
   begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask : close_out
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
   begin
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
   begin
      cpu_u.acc(1'b1, a, d, q);
   end
   endtask : wr
   task automatic rc(input logic [5:0] a, input logic [7:0] e, input string nm);
      logic [7:0] q;
   begin
      cpu_u.acc(1'b0, a, 8'h00, q);
      chk(nm, {8'h00, q}, {8'h00, e});
   end
   endtask : rc
   // Ticks two cycles apart, then let the last pulse land
   task automatic ticks(input int n);
   begin
      repeat (n)
      begin
         @(negedge clk);
         timer_tick = 1'b1;
         @(negedge clk);
         timer_tick = 1'b0;
      end
      repeat (2) @(negedge clk);
   end
   endtask : ticks
   task automatic ev(input int a, input int b, input int o, input string nm);
   begin
      chk(nm, 16'(n_a * 256 + n_b * 16 + n_o), 16'(a * 256 + b * 16 + o));
      n_a = 0;
      n_b = 0;
      n_o = 0;
   end
   endtask : ev
   // Hang guard
   initial
   begin
      #200000;
      err_count++;
      close_out();
   end
   // ************
   // Tests
   // ************
   initial
   begin
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      rc(TCB_ADDR_CTRL_A, 8'h00, "ctrl_rst");
      wr(TCB_ADDR_CTRL_A, 8'hFF);
      rc(TCB_ADDR_CTRL_A, 8'hF9, "ctrl_mask");
      chk("ctrl_port", {8'h00, ctrl}, 16'h00F9);
      rc(6'h3F, 8'h00, "unmapped");
      $display("done control");
      wr(TCB_ADDR_CTRL_A, 8'h80);
      cpu_u.wr16(TCB_ADDR_CNT_HI, TCB_ADDR_CNT_LO, 16'h1234);
      cpu_u.rd16(TCB_ADDR_CNT_LO, TCB_ADDR_CNT_HI, v);
      chk("cnt16", v, 16'h1234);
      wr(TCB_ADDR_CNT_HI, 8'hAB);
      wr(TCB_ADDR_CNT_LO, 8'h00);
      wr(TCB_ADDR_CMP_A, 8'h55);
      rc(TCB_ADDR_CMP_B, 8'hAB, "cmp_hi");
      rc(TCB_ADDR_CMP_A, 8'h55, "cmp_lo");
      cpu_u.rd16(TCB_ADDR_CNT_LO, TCB_ADDR_CNT_HI, v);
      chk("cnt_shared", v, 16'hAB00);
      $display("done access");
      cpu_u.wr16(TCB_ADDR_CMP_B, TCB_ADDR_CMP_A, 16'h0102);
      cpu_u.wr16(TCB_ADDR_CNT_HI, TCB_ADDR_CNT_LO, 16'h0100);
      ticks(4);
      ev(1, 0, 0, "cmp16");
      cpu_u.wr16(TCB_ADDR_CNT_HI, TCB_ADDR_CNT_LO, 16'hFFFE);
      ticks(2);
      ev(0, 0, 1, "wrap16");
      cpu_u.rd16(TCB_ADDR_CNT_LO, TCB_ADDR_CNT_HI, v);
      chk("zero16", v, 16'h0000);
      $display("done sixteen");
      wr(TCB_ADDR_CTRL_A, 8'h01);
      wr(TCB_ADDR_CMP_B, 8'h04);
      wr(TCB_ADDR_CMP_A, 8'h03);
      wr(TCB_ADDR_CNT_LO, 8'h00);
      ticks(8);
      ev(2, 0, 0, "ctc_period");
      wr(TCB_ADDR_CNT_LO, 8'h05);
      ticks(251);
      ev(0, 0, 1, "ctc_wrap");
      ticks(4);
      ev(1, 0, 0, "ctc_late");
      rc(TCB_ADDR_CNT_LO, 8'h00, "ctc_clear");
      $display("done clear on match");
      wr(TCB_ADDR_CTRL_A, 8'h00);
      wr(TCB_ADDR_CMP_A, 8'h07);
      wr(TCB_ADDR_CMP_B, 8'h08);
      wr(TCB_ADDR_CNT_LO, 8'h07);
      ticks(2);
      ev(0, 1, 0, "blocked");
      $display("done blocking");
      wr(TCB_ADDR_CTRL_A, 8'hC0);
      cpu_u.wr16(TCB_ADDR_CNT_HI, TCB_ADDR_CNT_LO, 16'h0456);
      @(negedge clk) capture_strobe = 1'b1;
      @(negedge clk) capture_strobe = 1'b0;
      chk("capt_evt", {15'h0000, capture_event}, 16'h0001);
      cpu_u.rd16(TCB_ADDR_CMP_A, TCB_ADDR_CMP_B, v);
      chk("capture16", v, 16'h0456);
      // Eight-bit capture leaves compare B as a plain register
      wr(TCB_ADDR_CTRL_A, 8'h40);
      wr(TCB_ADDR_CNT_LO, 8'h9A);
      @(negedge clk) capture_strobe = 1'b1;
      @(negedge clk) capture_strobe = 1'b0;
      rc(TCB_ADDR_CMP_A, 8'h9A, "capture8");
      rc(TCB_ADDR_CMP_B, 8'h04, "capt8_b");
      $display("done capture");
      close_out();
   end
endmodule : tb_top
